// >>> verilog/eipc_top.sv
// edge interrupt and pulse catch unit for six fast discrete inputs
// What this block does
// - six fast inputs can each request interrupts
// - per-input disable flag suppresses its interrupts
// - edges of legal-length levels are detected
// - pulse catch on the same six inputs
// - one catch flag per input, input order
// - every legal-length on pulse is caught
`timescale 1ns/1ns
module eipc_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // field inputs
  input  wire logic [5:0] fast_input,
  // program controls
  input  wire logic [5:0] edge_irq_mask,
  input  wire logic [5:0] irq_enable,
  input  wire logic [5:0] catch_enable,
  input  wire logic [5:0] caught_pulse_clear,
  input  wire logic       irq_ack,
  // program view
  output logic [5:0]      caught_pulse_flag,
  output logic [5:0]      input_level,
  output logic            irq_req,
  output logic [3:0]      input_edge_vector,
  output logic [5:0]      irq_pending_rise,
  output logic [5:0]      irq_pending_fall
);
  // ==========================================================
  // reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ==========================================================
  // input qualifiers, one per input
  logic [5:0] lvl;   // accepted levels
  logic [5:0] rise;  // accepted rising edges
  logic [5:0] fall;  // accepted falling edges

  genvar gi;
  generate
    for (gi = 0; gi < eipc_pkg::NUM_INPUTS; gi++) begin : g_flt
      // slow inputs get the longer window
      eipc_filter #(
        .WINDOW(eipc_pkg::SLOW_MASK[gi] ? 14'(eipc_pkg::SLOW_CYCLES)
                                        : 14'(eipc_pkg::FAST_CYCLES))
      ) u_flt (
        .clk       (clk),
        .rst_n     (rst_n_reg),
        .level_in  (fast_input[gi]),
        .level_out (lvl[gi]),
        .rise_pulse(rise[gi]),
        .fall_pulse(fall[gi])
      );
    end
  endgenerate

  // ==========================================================
  // vector code: input number high, edge in the low bit
  function automatic logic [3:0] vec_code(input logic [2:0] num, input logic edge_up);
    vec_code = {num, edge_up};
  endfunction

  // lowest pending request wins; none leaves the code unchanged
  function automatic logic [3:0] pick(input logic [5:0] pr, input logic [5:0] pf,
                                      input logic [3:0] keep);
    pick = keep;
    for (int k = 5; k >= 0; k--) begin
      if (pf[k]) pick = vec_code(3'(k), 1'b0);
      if (pr[k]) pick = vec_code(3'(k), 1'b1);
    end
  endfunction

  // ==========================================================
  // block state
  typedef struct packed {
    logic [5:0] caught;  // pulse catch flags
    logic [5:0] lvl;     // accepted levels shown to program
    logic [5:0] pr;      // pending rising requests
    logic [5:0] pf;      // pending falling requests
    logic       req;     // interrupt request
    logic [3:0] vec;     // vector of the served request
  } eipc_st_type;

  eipc_st_type st_reg;
  eipc_st_type st_next;

  // next state
  always_comb begin
    logic [5:0] armed;
    logic [5:0] pr_n;
    logic [5:0] pf_n;
    armed = irq_enable & ~edge_irq_mask;
    // acknowledge retires the served request
    pr_n  = st_reg.pr;
    pf_n  = st_reg.pf;
    if (irq_ack && st_reg.req) begin
      if (st_reg.vec[0]) pr_n[st_reg.vec[3:1]] = 1'b0;
      else               pf_n[st_reg.vec[3:1]] = 1'b0;
    end
    // new edges win over the acknowledge; masked inputs drop theirs
    pr_n = (pr_n | (rise & armed)) & armed;
    pf_n = (pf_n | (fall & armed)) & armed;
    st_next     = st_reg;
    st_next.pr  = pr_n;
    st_next.pf  = pf_n;
    st_next.req = |{pr_n, pf_n};
    st_next.vec = pick(pr_n, pf_n, st_reg.vec);
    st_next.lvl = lvl;
    // catch set beats clear; flag holds after the input drops
    st_next.caught = (st_reg.caught & ~caught_pulse_clear)
                   | (rise & catch_enable);
  end

  // registers
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output straight from the state register
  assign caught_pulse_flag = st_reg.caught;
  assign input_level       = st_reg.lvl;
  assign irq_req           = st_reg.req;
  assign input_edge_vector = st_reg.vec;
  assign irq_pending_rise  = st_reg.pr;
  assign irq_pending_fall  = st_reg.pf;

  // ==========================================================
  // checks
  sequence s_rise_seen(int k);
    rise[k] && catch_enable[k];
  endsequence

  property p_catch_set;
    @(posedge clk) disable iff (!rst_n_reg)
      (|(rise & catch_enable)) |=> (|(caught_pulse_flag & $past(rise & catch_enable)));
  endproperty
  a_catch_set: assert property (p_catch_set) else $error("caught pulse not flagged");

  // catch on input 1: the edge lands in its own flag one cycle later
  property p_catch_one;
    @(posedge clk) disable iff (!rst_n_reg)
      s_rise_seen(1) |=> caught_pulse_flag[1];
  endproperty
  a_catch_one: assert property (p_catch_one) else $error("input 1 pulse not flagged");

  property p_catch_hold;
    @(posedge clk) disable iff (!rst_n_reg)
      (caught_pulse_flag[0] && !caught_pulse_clear[0]) |=> caught_pulse_flag[0];
  endproperty
  a_catch_hold: assert property (p_catch_hold) else $error("catch flag lost");

  property p_catch_cause;
    @(posedge clk) disable iff (!rst_n_reg)
      $rose(caught_pulse_flag[2]) |-> $past(rise[2]);
  endproperty
  a_catch_cause: assert property (p_catch_cause) else $error("flag set without edge");

  property p_mask;
    @(posedge clk) disable iff (!rst_n_reg)
      (|edge_irq_mask) |=>
        (((irq_pending_rise | irq_pending_fall) & $past(edge_irq_mask)) == 6'h00);
  endproperty
  a_mask: assert property (p_mask) else $error("masked input pending");

  property p_rise_req;
    @(posedge clk) disable iff (!rst_n_reg)
      (rise[0] && irq_enable[0] && !edge_irq_mask[0]) |=> irq_req ##0 irq_pending_rise[0];
  endproperty
  a_rise_req: assert property (p_rise_req) else $error("rise not requested");

  property p_vec_bit;
    @(posedge clk) disable iff (!rst_n_reg)
      irq_req |-> (input_edge_vector[0] ? irq_pending_rise[input_edge_vector[3:1]]
                                        : irq_pending_fall[input_edge_vector[3:1]]);
  endproperty
  a_vec_bit: assert property (p_vec_bit) else $error("vector edge bit wrong");

  property p_req_any;
    @(posedge clk) disable iff (!rst_n_reg)
      irq_req == (|{irq_pending_rise, irq_pending_fall});
  endproperty
  a_req_any: assert property (p_req_any) else $error("request disagrees with pending");

  property p_level_follow;
    @(posedge clk) disable iff (!rst_n_reg)
      $rose(input_level[3]) |-> $past(fast_input[3], 2);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level change unqualified");

  property p_fall_no_catch;
    @(posedge clk) disable iff (!rst_n_reg)
      (fall[4] && !rise[4] && !caught_pulse_flag[4]) |=> !caught_pulse_flag[4];
  endproperty
  a_fall_no_catch: assert property (p_fall_no_catch) else $error("off edge caught");
endmodule

// >>> inc/eipc_pkg.sv
// constants shared by the edge interrupt and pulse catch block
package eipc_pkg;
  // ==========================================================
  // geometry
  localparam int NUM_INPUTS = 6;
  // ==========================================================
  // timing at 250 MHz
  localparam int CLK_MHZ       = 250;
  localparam int FAST_MIN_US   = 10;  // inputs 0, 1, 3, 4
  localparam int SLOW_MIN_US   = 50;  // inputs 2, 5
  // filter lengths: must sit below the least legal level time (rounded down)
  localparam int FAST_CYCLES   = FAST_MIN_US * CLK_MHZ / 2;
  localparam int SLOW_CYCLES   = SLOW_MIN_US * CLK_MHZ / 2;
  localparam int CNT_W         = 14;
  // inputs whose least level time is the long one
  localparam logic [5:0] SLOW_MASK = 6'h24;
  // ==========================================================
  // values after reset
  localparam logic [5:0]  RST_FLAGS  = 6'h00;
  localparam logic [3:0]  RST_VECTOR = 4'h0;
  localparam logic [CNT_W-1:0] RST_CNT = 14'h0000;
endpackage

// >>> verilog/eipc_filter.sv
// one input qualifier: a level must hold a full window before it is accepted
`timescale 1ns/1ns
module eipc_filter #(
  parameter logic [13:0] WINDOW = 14'h04E2
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw level and qualified result
  input  wire logic level_in,
  output logic      level_out,
  output logic      rise_pulse,
  output logic      fall_pulse
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [eipc_pkg::CNT_W-1:0] cnt;  // cycles the raw level differs
    logic                       lvl;  // accepted level
    logic                       rise; // one-cycle edge pulses
    logic                       fall;
  } eipc_flt_type;

  eipc_flt_type st_reg;
  eipc_flt_type st_next;

  // next state: count disagreement, flip once the window is full
  always_comb begin
    st_next      = st_reg;
    st_next.rise = 1'b0;
    st_next.fall = 1'b0;
    if (level_in == st_reg.lvl) begin
      // glitch shorter than the window is dropped
      st_next.cnt = eipc_pkg::RST_CNT;
    end else if (st_reg.cnt == WINDOW - 14'h0001) begin
      st_next.cnt  = eipc_pkg::RST_CNT;
      st_next.lvl  = level_in;
      st_next.rise = level_in;
      st_next.fall = ~level_in;
    end else begin
      st_next.cnt = st_reg.cnt + 14'h0001;
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out  = st_reg.lvl;
  assign rise_pulse = st_reg.rise;
  assign fall_pulse = st_reg.fall;
endmodule

// >>> tb/eipc_field.sv
// field switch model driving the six fast discrete inputs
`timescale 1ns/1ns
module eipc_field (
  // clock
  clk,
  // contact levels seen by the unit
  fast_input
);
  // clock
  input  wire logic  clk;
  // contact levels seen by the unit
  output logic [5:0] fast_input;
  // all contacts open at power-up
  initial fast_input = 6'h00;
  // ==========================================================
  // move the selected contacts to level v on a falling edge and keep them n cycles;
  // a level is never changed early, so short contact bounce is not modelled
  task automatic hold(input logic [5:0] sel, input logic v, input int n);
    @(negedge clk);
    fast_input = v ? (fast_input | sel) : (fast_input & ~sel);
    repeat (n - 1) @(negedge clk);
  endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the edge interrupt and pulse catch unit
`timescale 1ns/1ns
module tb;
  // ==========================================================
  // clock, reset and program controls
  logic       clk;
  logic       reset_n;
  logic [5:0] fast_input;
  logic [5:0] edge_irq_mask;
  logic [5:0] irq_enable;
  logic [5:0] catch_enable;
  logic [5:0] caught_pulse_clear;
  logic       irq_ack;
  // program view
  logic [5:0] caught_pulse_flag;
  logic [5:0] input_level;
  logic       irq_req;
  logic [3:0] input_edge_vector;
  logic [5:0] irq_pending_rise;
  logic [5:0] irq_pending_fall;
  // score keeping
  int         failures;
  int         checked;
  // ==========================================================
  // unit under test and the field contacts
  eipc_top dut (.clk(clk), .reset_n(reset_n), .fast_input(fast_input),
    .edge_irq_mask(edge_irq_mask), .irq_enable(irq_enable), .catch_enable(catch_enable),
    .caught_pulse_clear(caught_pulse_clear), .irq_ack(irq_ack),
    .caught_pulse_flag(caught_pulse_flag), .input_level(input_level), .irq_req(irq_req),
    .input_edge_vector(input_edge_vector), .irq_pending_rise(irq_pending_rise),
    .irq_pending_fall(irq_pending_fall));
  eipc_field field (.clk(clk), .fast_input(fast_input));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // compare one value, case equality so unknowns never match
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle acknowledge of the shown vector
  task automatic do_ack();
    @(negedge clk) irq_ack = 1'b1;
    @(negedge clk) irq_ack = 1'b0;
  endtask
  // one-cycle clear of selected catch flags
  task automatic do_clear(input logic [5:0] sel);
    @(negedge clk) caught_pulse_clear = sel;
    @(negedge clk) caught_pulse_clear = 6'h00;
  endtask
  // verdict, reached from the main sequence or the watchdog
  task automatic test_done();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // input 0 on interrupt, input 1 on catch: vectors, flag held until cleared
  task automatic t_rise_fall();
    irq_enable = 6'h01;
    catch_enable = 6'h02;
    field.hold(6'h03, 1'b1, 1300);
    check(irq_req, 1'b1);
    check(input_edge_vector, 4'h1);
    check(irq_pending_rise, 6'h01);
    check(caught_pulse_flag, 6'h02);
    do_ack();
    check(irq_req, 1'b0);
    field.hold(6'h03, 1'b1, 1300);
    field.hold(6'h03, 1'b0, 1300);
    check(input_edge_vector, 4'h0);
    check(irq_pending_fall, 6'h01);
    check(caught_pulse_flag, 6'h02);
    do_ack();
    do_clear(6'h02);
    check(caught_pulse_flag, 6'h00);
  endtask
  // masked interrupt input 3: no requests; catch on input 0 beside it
  task automatic t_mask();
    edge_irq_mask = 6'h08;
    irq_enable = 6'h08;
    catch_enable = 6'h01;
    field.hold(6'h09, 1'b1, 1300);
    check(irq_req, 1'b0);
    check(caught_pulse_flag, 6'h01);
    field.hold(6'h09, 1'b0, 1300);
    check(irq_pending_fall, 6'h00);
    do_clear(6'h01);
    edge_irq_mask = 6'h00;
  endtask
  // slow input 5 on interrupt, slow input 2 on catch: nothing before the long window
  task automatic t_slow();
    irq_enable = 6'h20;
    catch_enable = 6'h04;
    field.hold(6'h24, 1'b1, 6000);
    check(input_level, 6'h00);
    field.hold(6'h24, 1'b1, 300);
    check(input_edge_vector, 4'hB);
    check(caught_pulse_flag, 6'h04);
    do_ack();
    field.hold(6'h24, 1'b1, 6300);
    field.hold(6'h24, 1'b0, 6300);
    check(input_edge_vector, 4'hA);
    do_ack();
    check(irq_req, 1'b0);
    do_clear(6'h04);
  endtask
  // inputs 1 and 4 together, catch off: lowest input shown first
  task automatic t_order();
    irq_enable = 6'h12;
    catch_enable = 6'h00;
    field.hold(6'h12, 1'b1, 1300);
    check(input_edge_vector, 4'h3);
    check(caught_pulse_flag, 6'h00);
    do_ack();
    check(input_edge_vector, 4'h9);
    do_ack();
    field.hold(6'h12, 1'b1, 1300);
    field.hold(6'h12, 1'b0, 1300);
    check(irq_pending_fall, 6'h12);
    do_ack();
    do_ack();
    check(irq_req, 1'b0);
    irq_enable = 6'h00;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    failures = 0;
    checked = 0;
    reset_n = 1'b0;
    edge_irq_mask = 6'h00;
    irq_enable = 6'h00;
    catch_enable = 6'h00;
    caught_pulse_clear = 6'h00;
    irq_ack = 1'b0;
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    t_rise_fall();
    t_mask();
    t_slow();
    t_order();
    test_done();
  end
  // watchdog: tests need about 29300 cycles
  initial begin
    #200000;
    failures++;
    test_done();
  end
endmodule
